// >>> design/rcn_defs.svh
`ifndef RCN_DEFS_SVH
`define RCN_DEFS_SVH
// Register addresses on the plain register port.
`define RCN_ADDR_RESET_CAUSE 4'h0
`define RCN_ADDR_NMI_CONTROL 4'h4
// Reset cause field positions.
`define RCN_RC_SUPPLY_POR 31
`define RCN_RC_CORE_POR 30
`define RCN_RC_CFG_ERR 27
`define RCN_RC_CFG_FAIL 26
`define RCN_RC_CFG_MISMATCH 9
`define RCN_RC_PIN_RESET 7
`define RCN_RC_SOFT_RESET 6
`define RCN_RC_WDT_TIMEOUT 4
`define RCN_RC_SLEEP 3
`define RCN_RC_IDLE 2
`define RCN_RC_BROWNOUT 1
`define RCN_RC_POR 0
// Implemented bits of the reset cause register, and its value at power-on.
`define RCN_RC_MASK 32'hCC0002DF
`define RCN_RC_RESET 32'hC0000003
// Interrupt control field positions.
`define RCN_NC_RUN_WDT 24
`define RCN_NC_SOFT_NMI 23
`define RCN_NC_GEN_NMI 19
`define RCN_NC_CLK_FAIL 17
`define RCN_NC_SLEEP_WDT 16
`define RCN_NC_RELOAD_LSB 0
`define RCN_NC_RELOAD_MSB 15
`define RCN_NC_RELOAD_RESET 16'h0000
`endif

// >>> design/rcn_pkg.sv
package rcn_pkg;
   // Delay counter sequencing states, Gray coded from RCN_IDLE through RCN_COUNT to RCN_FIRE; RCN_FIRE back to RCN_IDLE changes two bits.
   typedef enum logic [1:0]
   {
      RCN_IDLE = 2'b00,
      RCN_COUNT = 2'b01,
      RCN_FIRE = 2'b11
   } rcn_state_t;
endpackage

// >>> design/rcn_reset_nmi.sv
// Functional notes
// (R1) Supply power-on event sets the top reset cause flag.
// (R2) Core power-on event sets the core power-on flag.
// (R3) Primary configuration read error sets its flag.
// (R4) Error reading both configuration copies sets the failure flag.
// (R5) Configuration mismatch reset sets its flag.
// (R6) Master clear pin reset sets the pin reset flag.
// (R7) Software reset sets the soft reset flag.
// (R8) Watchdog time-out sets the watchdog time-out flag.
// (R9) Wake from sleep also sets the idle flag.
// (R10) Cause flags stay set until software clears them.
// (R11) Run watchdog time-out or software write of one raises NMI and starts delay.
// (R12) Software interrupt trigger raises NMI and reads one while recorded.
// (R13) General trigger raises general NMI and reads one while recorded.
// (R14) Clock failure or software write sets clock-fail flag and raises NMI.
// (R15) Sleep watchdog time-out sets flag, wakes; software set raises NMI.
// (R16) Nonzero reload gives system clock cycles before device reset.
// (R17) Zero reload resets at once when the watchdog interrupt asserts.
// (R18) Clearing the run watchdog flag before expiry prevents the reset.
// (R19) Only the run watchdog interrupt starts the delay counter.
// (R20) Interrupt control writes need the unlock sequence, else ignored.
// (R21) Unimplemented bits read zero and ignore writes.
// (R22) Clock failure switches the clock to the fast RC oscillator and raises NMI.
// (R23) No clock failure is detected or flagged while asleep.
// (R24) A write-permit input from the lock controller gates control writes.
`timescale 1ns/1ps
`default_nettype none
`include "rcn_defs.svh"
module rcn_reset_nmi #(
   parameter int RELOAD_W = 16
)(
   input wire logic sys_clk, // System clock, 200 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic [3:0] reg_addr, // Register byte address.
   input wire logic [31:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [31:0] reg_rdata, // Read data, the cycle after the read strobe.
   input wire logic write_permit, // Unlock granted by the lock controller.
   input wire logic supply_por_evt, // Supply power-on reset detected.
   input wire logic core_por_evt, // Core power-on reset detected.
   input wire logic cfg_err_evt, // Primary configuration read error.
   input wire logic cfg_fail_evt, // Both configuration copies failed.
   input wire logic cfg_mismatch_evt, // Configuration mismatch reset.
   input wire logic pin_reset_evt, // Master clear pin reset.
   input wire logic soft_reset_evt, // Software reset executed.
   input wire logic wdt_timeout_evt, // Watchdog time-out, any mode.
   input wire logic sleep_entry_evt, // Device entered sleep.
   input wire logic idle_entry_evt, // Device entered idle.
   input wire logic sleep_wake_evt, // Device woke from sleep.
   input wire logic brownout_evt, // Brown-out reset.
   input wire logic por_evt, // Generic power-on reset.
   input wire logic in_sleep, // Device is in sleep.
   input wire logic clock_fail_evt, // Clock monitor failure detection.
   output logic nmi_pulse, // One-cycle non-maskable interrupt request.
   output logic wake_req, // One-cycle wake request from sleep watchdog.
   output logic clk_to_fast_rc, // System clock switched to the fast RC.
   output logic device_reset // One-cycle device reset request.
);

   initial
   begin
      if (RELOAD_W < 1 || RELOAD_W > 16)
      begin
         $error("RELOAD_W must lie between 1 and 16");
      end
   end

   logic [31:0] cause_r;
   logic run_wdt_r;
   logic soft_nmi_r;
   logic gen_nmi_r;
   logic clk_fail_r;
   logic sleep_wdt_r;
   logic [RELOAD_W-1:0] reload_r;
   logic [RELOAD_W-1:0] count_r;
   rcn_pkg::rcn_state_t state_r;
   logic [31:0] cause_set;
   logic nc_wr;
   logic rc_wr;
   logic run_wdt_evt;
   logic sleep_wdt_evt;
   logic cf_evt;
   logic run_wdt_sw;
   logic run_wdt_start;
   logic [RELOAD_W-1:0] reload_eff;
   logic [31:0] ctl_word;
   logic sw_rise;

   // Decodes a write of one into a given control bit.
   function automatic logic wr_one(input logic en, input logic [31:0] d, input int pos);
      wr_one = en & d[pos];
   endfunction

   // Address decode; control writes only pass while the lock controller permits.
   assign rc_wr = reg_wr && (reg_addr == `RCN_ADDR_RESET_CAUSE);
   assign nc_wr = reg_wr && (reg_addr == `RCN_ADDR_NMI_CONTROL) && write_permit; // [R20] [R24]

   // Watchdog time-out splits by mode; the clock monitor is stopped in sleep.
   assign run_wdt_evt = wdt_timeout_evt && !in_sleep;
   assign sleep_wdt_evt = wdt_timeout_evt && in_sleep;
   assign cf_evt = clock_fail_evt && !in_sleep; // [R23]
   assign run_wdt_sw = wr_one(nc_wr, reg_wdata, `RCN_NC_RUN_WDT) && !run_wdt_r;
   assign run_wdt_start = run_wdt_evt || run_wdt_sw; // [R19]

   // A reload written together with a start takes effect for that very start.
   assign reload_eff = nc_wr ? reg_wdata[RELOAD_W-1:0] : reload_r; // [R16]

   // Software writes of one into a clear flag; each such write raises one interrupt.
   assign sw_rise = (wr_one(nc_wr, reg_wdata, `RCN_NC_SOFT_NMI) && !soft_nmi_r) // [R12]
      || (wr_one(nc_wr, reg_wdata, `RCN_NC_GEN_NMI) && !gen_nmi_r) // [R13]
      || (wr_one(nc_wr, reg_wdata, `RCN_NC_CLK_FAIL) && !clk_fail_r) // [R14]
      || (wr_one(nc_wr, reg_wdata, `RCN_NC_SLEEP_WDT) && !sleep_wdt_r); // [R15]

   // Hardware set vector for the reset cause register.
   always_comb
   begin
      cause_set = 32'h00000000;
      cause_set[`RCN_RC_SUPPLY_POR] = supply_por_evt; // [R1]
      cause_set[`RCN_RC_CORE_POR] = core_por_evt; // [R2]
      cause_set[`RCN_RC_CFG_ERR] = cfg_err_evt; // [R3]
      cause_set[`RCN_RC_CFG_FAIL] = cfg_fail_evt; // [R4]
      cause_set[`RCN_RC_CFG_MISMATCH] = cfg_mismatch_evt; // [R5]
      cause_set[`RCN_RC_PIN_RESET] = pin_reset_evt; // [R6]
      cause_set[`RCN_RC_SOFT_RESET] = soft_reset_evt; // [R7]
      cause_set[`RCN_RC_WDT_TIMEOUT] = wdt_timeout_evt; // [R8]
      cause_set[`RCN_RC_SLEEP] = sleep_entry_evt;
      cause_set[`RCN_RC_IDLE] = idle_entry_evt || sleep_wake_evt; // [R9]
      cause_set[`RCN_RC_BROWNOUT] = brownout_evt;
      cause_set[`RCN_RC_POR] = por_evt;
   end

   // Reset cause flags: written value stored, hardware set wins over a clear.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cause_r <= `RCN_RC_RESET;
      end
      else
      begin
         cause_r <= ((rc_wr ? reg_wdata : cause_r) | cause_set) & `RCN_RC_MASK; // [R10] [R21]
      end
   end

   // Run-mode watchdog interrupt flag; hardware set wins over a software clear.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_wdt_r <= 1'b0;
      end
      else if (run_wdt_evt)
      begin
         run_wdt_r <= 1'b1; // [R11]
      end
      else if (nc_wr)
      begin
         run_wdt_r <= reg_wdata[`RCN_NC_RUN_WDT]; // [R11] [R18]
      end
   end

   // Software interrupt triggers, set and cleared by permitted control writes.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         soft_nmi_r <= 1'b0;
         gen_nmi_r <= 1'b0;
      end
      else if (nc_wr)
      begin
         soft_nmi_r <= reg_wdata[`RCN_NC_SOFT_NMI]; // [R12]
         gen_nmi_r <= reg_wdata[`RCN_NC_GEN_NMI]; // [R13]
      end
   end

   // Sleep watchdog flag; a time-out in sleep wins over a same-cycle write.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sleep_wdt_r <= 1'b0;
      end
      else if (sleep_wdt_evt)
      begin
         sleep_wdt_r <= 1'b1; // [R15]
      end
      else if (nc_wr)
      begin
         sleep_wdt_r <= reg_wdata[`RCN_NC_SLEEP_WDT]; // [R15]
      end
   end

   // Clock-fail flag; a real failure wins over a same-cycle software write.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clk_fail_r <= 1'b0;
      end
      else if (cf_evt)
      begin
         clk_fail_r <= 1'b1; // [R14]
      end
      else if (nc_wr)
      begin
         clk_fail_r <= reg_wdata[`RCN_NC_CLK_FAIL]; // [R14]
      end
   end

   // Clock source switch, sticky until reset; a software set never switches it.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clk_to_fast_rc <= 1'b0;
      end
      else if (cf_evt)
      begin
         clk_to_fast_rc <= 1'b1; // [R22]
      end
   end

   // Reload field, writable only with permission.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reload_r <= RELOAD_W'(`RCN_NC_RELOAD_RESET);
      end
      else if (nc_wr)
      begin
         reload_r <= reg_wdata[RELOAD_W-1:0]; // [R16]
      end
   end

   // Non-maskable interrupt request on any rising source, including software sets.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         nmi_pulse <= 1'b0;
      end
      else
      begin
         nmi_pulse <= run_wdt_start || cf_evt || sleep_wdt_evt || sw_rise; // [R11] [R22]
      end
   end

   // Wake request, one cycle long, for a watchdog time-out during sleep.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wake_req <= 1'b0;
      end
      else
      begin
         wake_req <= sleep_wdt_evt; // [R15]
      end
   end

   // Delay counter: loaded on a start, then counts system clock cycles while armed.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count_r <= '0;
      end
      else if (state_r == rcn_pkg::RCN_IDLE && run_wdt_start)
      begin
         count_r <= reload_eff; // [R16] [R19]
      end
      else if (state_r == rcn_pkg::RCN_COUNT && run_wdt_r)
      begin
         count_r <= count_r - RELOAD_W'(1); // [R16]
      end
   end

   // Reset delay sequencer: arms only for the run-mode watchdog interrupt.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= rcn_pkg::RCN_IDLE;
      end
      else
      begin
         case (state_r)
            rcn_pkg::RCN_IDLE:
            begin
               if (run_wdt_start && reload_eff == '0)
               begin
                  state_r <= rcn_pkg::RCN_FIRE; // [R17]
               end
               else if (run_wdt_start)
               begin
                  state_r <= rcn_pkg::RCN_COUNT; // [R19]
               end
            end
            rcn_pkg::RCN_COUNT:
            begin
               if (!run_wdt_r)
               begin
                  state_r <= rcn_pkg::RCN_IDLE; // [R18]
               end
               else if (count_r == RELOAD_W'(1))
               begin
                  state_r <= rcn_pkg::RCN_FIRE; // [R16]
               end
            end
            rcn_pkg::RCN_FIRE:
            begin
               state_r <= rcn_pkg::RCN_IDLE;
            end
            default:
            begin
               state_r <= rcn_pkg::RCN_IDLE;
            end
         endcase
      end
   end

   // Device reset request, one cycle long.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         device_reset <= 1'b0;
      end
      else
      begin
         device_reset <= (state_r == rcn_pkg::RCN_IDLE) && run_wdt_start
            && (reload_eff == '0); // [R17]
         if (state_r == rcn_pkg::RCN_COUNT && run_wdt_r && count_r == RELOAD_W'(1))
         begin
            device_reset <= 1'b1; // [R16]
         end
      end
   end

   // Interrupt control word as software reads it; unimplemented bits stay zero.
   always_comb
   begin
      ctl_word = 32'h00000000; // [R21]
      ctl_word[`RCN_NC_RUN_WDT] = run_wdt_r; // [R11]
      ctl_word[`RCN_NC_SOFT_NMI] = soft_nmi_r; // [R12]
      ctl_word[`RCN_NC_GEN_NMI] = gen_nmi_r; // [R13]
      ctl_word[`RCN_NC_CLK_FAIL] = clk_fail_r; // [R14]
      ctl_word[`RCN_NC_SLEEP_WDT] = sleep_wdt_r; // [R15]
      ctl_word[RELOAD_W-1:0] = reload_r; // [R16]
   end

   // Read data, valid the cycle after the read strobe; unmapped reads give zero.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata <= 32'h00000000;
      end
      else if (reg_rd && reg_addr == `RCN_ADDR_RESET_CAUSE)
      begin
         reg_rdata <= cause_r;
      end
      else if (reg_rd && reg_addr == `RCN_ADDR_NMI_CONTROL)
      begin
         reg_rdata <= ctl_word; // [R21]
      end
      else
      begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // rcn_reset_nmi
`default_nettype wire

// >>> test/rcn_reset_nmi_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcn_defs.svh"
module rcn_reset_nmi_chk (
   input wire logic sys_clk, // Clock.
   input wire logic resetn, // Reset, active low.
   input wire logic [3:0] reg_addr, // Address.
   input wire logic reg_rd, // Read strobe.
   input wire logic [31:0] reg_rdata, // Read data.
   input wire logic wdt_timeout_evt, // Watchdog time-out.
   input wire logic in_sleep, // Sleep level.
   input wire logic clock_fail_evt, // Clock failure.
   input wire logic nmi_pulse, // Interrupt pulse.
   input wire logic wake_req, // Wake pulse.
   input wire logic clk_to_fast_rc, // Clock switched.
   input wire logic device_reset // Reset pulse.
);
   // All checks sample on the system clock and rest while reset is low.
   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_fast_rc_sticky: assert property (clk_to_fast_rc |=> clk_to_fast_rc)
      else $error("fast rc selection dropped");
   a_fail_switches: assert property (clock_fail_evt && !in_sleep |=> clk_to_fast_rc && nmi_pulse)
      else $error("clock failure not handled");
   a_sleep_no_fail: assert property (clock_fail_evt && in_sleep && !clk_to_fast_rc |=> !clk_to_fast_rc)
      else $error("clock failure taken in sleep");
   a_sleep_wdt_wake: assert property (wdt_timeout_evt && in_sleep |=> wake_req)
      else $error("no wake on sleep time-out");
   a_run_wdt_nmi: assert property (wdt_timeout_evt && !in_sleep |=> nmi_pulse)
      else $error("no interrupt on run time-out");
   a_reset_single: assert property ($rose(device_reset) |=> !device_reset)
      else $error("reset pulse too long");
   a_ctrl_reserved: assert property (reg_rd && reg_addr == 4'h4 |=> (reg_rdata & 32'hFE740000) == 32'h0)
      else $error("reserved control bits set");
   a_unmapped_zero: assert property (reg_rd && reg_addr != 4'h0 && reg_addr != 4'h4 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // rcn_reset_nmi_chk
bind rcn_reset_nmi rcn_reset_nmi_chk rcn_reset_nmi_chk_i (.sys_clk(sys_clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_sleep(in_sleep),
   .wdt_timeout_evt(wdt_timeout_evt), .clock_fail_evt(clock_fail_evt), .nmi_pulse(nmi_pulse),
   .wake_req(wake_req), .clk_to_fast_rc(clk_to_fast_rc), .device_reset(device_reset));
`default_nettype wire

// >>> test/rcn_event_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcn_event_model (
   input wire logic sys_clk, // Clock.
   output logic [13:0] evt, // One pulse line per event source.
   output logic in_sleep // High while asleep.
);
   // Sources stay quiet until told to fire.
   initial
   begin
      evt = '0;
      in_sleep = 1'b0;
   end
   // Raises one source for exactly one clock, launched after an edge.
   task fire(input int k);
      @(posedge sys_clk);
      evt[k] <= 1'b1;
      @(posedge sys_clk);
      evt <= '0;
   endtask
   // Enters or leaves sleep after an edge.
   task sleep(input logic s);
      @(posedge sys_clk);
      in_sleep <= s;
   endtask
endmodule // rcn_event_model
`default_nettype wire

// >>> test/rcn_reset_nmi_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcn_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module rcn_reset_nmi_test;
   logic sys_clk, resetn, reg_wr, reg_rd, write_permit, in_sleep;
   logic nmi_pulse, wake_req, clk_to_fast_rc, device_reset;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [13:0] evt;
   int error_cnt = 0;
   int comparisons = 0;
   int n;
   int bit_of [13] = '{31, 30, 27, 26, 9, 7, 6, 4, 3, 2, 2, 1, 0};
   int nv [3] = '{0, 1, 20};
   // Block under test with every event line driven by the source model.
   rcn_reset_nmi rcn_reset_nmi_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .write_permit(write_permit), .supply_por_evt(evt[0]), .core_por_evt(evt[1]),
      .cfg_err_evt(evt[2]), .cfg_fail_evt(evt[3]), .cfg_mismatch_evt(evt[4]),
      .pin_reset_evt(evt[5]), .soft_reset_evt(evt[6]), .wdt_timeout_evt(evt[7]),
      .sleep_entry_evt(evt[8]), .idle_entry_evt(evt[9]), .sleep_wake_evt(evt[10]),
      .brownout_evt(evt[11]), .por_evt(evt[12]), .in_sleep(in_sleep),
      .clock_fail_evt(evt[13]), .nmi_pulse(nmi_pulse), .wake_req(wake_req),
      .clk_to_fast_rc(clk_to_fast_rc), .device_reset(device_reset));
   rcn_event_model rcn_event_model_i (.sys_clk(sys_clk), .evt(evt), .in_sleep(in_sleep));
   // Free-running 200 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Register port write and read, each one strobe cycle.
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rdr(input logic [3:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Waits for a pulse on nmi (0), reset (1) or wake (2); n is cycles or -1.
   task wait_out(input int sel, input int lim, input bit must);
      n = -1;
      for (int i = 0; i <= lim; i++)
      begin
         #1;
         if ((sel == 0 ? nmi_pulse : sel == 1 ? device_reset : wake_req) === 1'b1)
         begin
            n = i;
            break;
         end
         @(posedge sys_clk);
      end
      if (must && n < 0)
      begin
         error_cnt++;
         $display("wrong value pulse_%0d expected 1 seen none", sel);
         end_of_test;
      end
   endtask
   task end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task t_causes;
      rdr(4'h0); `CHK("cause reset", 32'hC0000003, rd)
      rdr(4'h8); `CHK("unmapped", 32'h0, rd)
      for (int k = 0; k < 13; k++)
      begin
         wr(4'h0, 32'h0);
         rcn_event_model_i.fire(k);
         rdr(4'h0); `CHK("cause bit", 1'b1, rd[bit_of[k]])
      end
      repeat (4) @(posedge sys_clk);
      rdr(4'h0); `CHK("cause held", 1'b1, rd[0])
      wr(4'h0, 32'hFFFFFFFF);
      rdr(4'h0); `CHK("cause mask", `RCN_RC_MASK, rd)
      wr(4'h0, 32'h0);
      rdr(4'h0); `CHK("cause clear", 32'h0, rd)
      wr(4'h4, 32'h0);
   endtask
   task t_triggers;
      @(posedge sys_clk);
      write_permit <= 1'b0;
      wr(4'h4, 32'h00080000); wait_out(0, 3, 0); `CHK("locked nmi", -1, n)
      rdr(4'h4); `CHK("locked write", 32'h0, rd)
      write_permit <= 1'b1;
      wr(4'h4, 32'h00080000); wait_out(0, 3, 1);
      rdr(4'h4); `CHK("general trigger", 32'h00080000, rd)
      wr(4'h4, 32'h00800000); wait_out(0, 3, 1);
      rdr(4'h4); `CHK("soft trigger", 32'h00800000, rd)
      wr(4'h4, 32'hFE740000);
      rdr(4'h4); `CHK("control mask", 32'h0, rd)
   endtask
   task t_sleep_fail;
      rcn_event_model_i.sleep(1'b1);
      rcn_event_model_i.fire(13);
      rdr(4'h4); `CHK("sleep fail", 32'h0, rd)
      rcn_event_model_i.fire(7); wait_out(2, 3, 1); `CHK("wake time", 0, n)
      rdr(4'h4); `CHK("sleep flag", 32'h00010000, rd)
      rcn_event_model_i.sleep(1'b0);
      wr(4'h4, 32'h0);
      wr(4'h4, 32'h00020000); wait_out(0, 3, 1); `CHK("soft fail", 1'b1, nmi_pulse)
      `CHK("soft no switch", 1'b0, clk_to_fast_rc)
      wr(4'h4, 32'h0);
      rcn_event_model_i.fire(13); wait_out(0, 3, 1); `CHK("fail nmi", 0, n)
      `CHK("fast rc", 1'b1, clk_to_fast_rc)
      rdr(4'h4); `CHK("fail flag", 32'h00020000, rd)
      wait_out(1, 10, 0); `CHK("fail reset", -1, n)
      wr(4'h4, 32'h0);
   endtask
   task t_delay;
      for (int i = 0; i < 3; i++)
      begin
         wr(4'h4, nv[i]);
         rcn_event_model_i.fire(7); wait_out(1, 40, 1); `CHK("delay", nv[i], n)
         rdr(4'h4); `CHK("run flag", 32'h01000000 | nv[i], rd)
         wr(4'h4, nv[i]);
      end
      wr(4'h4, 32'd20);
      rcn_event_model_i.fire(7);
      repeat (5) @(posedge sys_clk);
      wr(4'h4, 32'd20); wait_out(1, 40, 0); `CHK("aborted", -1, n)
      wr(4'h4, 32'h01000003); wait_out(1, 10, 1); `CHK("soft run", 3, n)
      wr(4'h4, 32'h0);
   endtask
   // Reset for three cycles, then each scenario in turn.
   initial
   begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      write_permit = 1'b1;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      t_causes;
      t_triggers;
      t_sleep_fail;
      t_delay;
      end_of_test;
   end
endmodule // rcn_reset_nmi_test
`default_nettype wire
